/* design/acc_xfer_regs.svh */
`ifndef ACC_XFER_REGS_SVH
`define ACC_XFER_REGS_SVH

// Widths of an accumulator and its parts
`define ACC_W        56
`define WORD_W       24
`define TOP_W        8
// Field positions inside an accumulator
`define TOP_MSB      55
`define TOP_LSB      48
`define UPPER_MSB    47
`define UPPER_LSB    24
`define LOWER_MSB    23
// Saturation constants for one bus word
`define SAT_POS_HI   24'h7FFFFF
`define SAT_POS_LO   24'hFFFFFF
`define SAT_NEG_HI   24'h800000
`define SAT_NEG_LO   24'h000000
// Reset value of every accumulator part
`define ACC_RESET    56'h00000000000000
// Pre-accumulation shift distances
`define PRE_SHIFT_WORD 24
`define PRE_SHIFT_HALF 16

`endif

/* design/acc_xfer_pkg.sv */
package acc_xfer_pkg;

  // Scaling field; the fourth code is reserved and acts as no scaling
  typedef enum logic [1:0] {
    SCALE_NONE = 2'h0,
    SCALE_DOWN = 2'h1,
    SCALE_UP   = 2'h2,
    SCALE_RSVD = 2'h3
  } scale_type;

  // Which part of an accumulator a move names
  typedef enum logic [1:0] {
    PART_WHOLE = 2'h0,
    PART_TOP   = 2'h1,
    PART_UPPER = 2'h2,
    PART_LOWER = 2'h3
  } part_type;

  // Kind of operand written into an accumulator
  typedef enum logic [2:0] {
    WR_WORD  = 3'h0,
    WR_LONG  = 3'h1,
    WR_TOP   = 3'h2,
    WR_UPPER = 3'h3,
    WR_LOWER = 3'h4
  } wr_kind_type;

  // Pre-accumulation shifter modes
  typedef enum logic [1:0] {
    PRE_PASS   = 2'h0,
    PRE_SHR24  = 2'h1,
    PRE_SHR16  = 2'h2,
    PRE_ZERO   = 2'h3
  } pre_mode_type;

  // Bit-field block operations
  typedef enum logic [3:0] {
    BF_SHIFT_LEFT_SIGNED  = 4'h0,
    BF_SHIFT_LEFT_PLAIN   = 4'h1,
    BF_SHIFT_RIGHT_SIGNED = 4'h2,
    BF_SHIFT_RIGHT_PLAIN  = 4'h3,
    BF_ROTATE_RIGHT_ONE   = 4'h4,
    BF_ROTATE_LEFT_ONE    = 4'h5,
    BF_FIELD_MERGE        = 4'h6,
    BF_FIELD_INSERT       = 4'h7,
    BF_FIELD_PULL_SIGNED  = 4'h8,
    BF_FIELD_PULL_UNSIGNED = 4'h9,
    BF_LEADING_BIT_COUNT  = 4'hA,
    BF_FAST_NORMALIZE     = 4'hB,
    BF_AND                = 4'hC,
    BF_OR                 = 4'hD,
    BF_EXCLUSIVE_OR_OP    = 4'hE,
    BF_NOT                = 4'hF
  } bf_op_type;

  // A read request from one data bus
  typedef struct packed {
    logic     en;
    logic     acc;
    part_type part;
  } rd_req_type;

  // A write request into an accumulator
  typedef struct packed {
    logic        en;
    logic        acc;
    wr_kind_type kind;
    logic [47:0] data;
  } wr_req_type;

  // A bit-field request
  typedef struct packed {
    logic        en;
    bf_op_type   op;
    logic [55:0] a;
    logic [55:0] b;
    logic [5:0]  amt;
    logic [5:0]  width;
    logic [5:0]  offset;
  } bf_req_type;

endpackage

/* design/accumulator_transfer_limiter.sv */
`timescale 1ns/1ps
`include "acc_xfer_regs.svh"

module accumulator_transfer_limiter
  import acc_xfer_pkg::*;
(
  input  wire logic        ref_clk_i,         // Core clock, 50 MHz
  input  wire logic        rst_n_i,           // Asynchronous reset, active low
  input  wire scale_type   scale_i,           // Scaling mode from the status word
  input  wire rd_req_type  rd_first_i,        // Read request, first data bus
  input  wire rd_req_type  rd_second_i,       // Read request, second data bus
  input  wire logic        rd_long_i,         // Long read: first request feeds both buses
  input  wire wr_req_type  wr_req_i,          // Operand write from a data bus
  input  wire logic        alu_wr_i,          // Arithmetic result write strobe
  input  wire logic        alu_acc_i,         // Arithmetic result target accumulator
  input  wire logic [55:0] alu_data_i,        // Arithmetic result, 56 bits
  input  wire logic        pre_acc_i,         // Pre-shifter source accumulator
  input  wire pre_mode_type pre_mode_i,       // Pre-shifter mode
  input  wire bf_req_type  bf_req_i,          // Bit-field request
  input  wire logic        limit_clr_i,       // Clears the limit flag
  output logic [23:0]      first_data_bus_o,  // Word driven on first data bus
  output logic [23:0]      second_data_bus_o, // Word driven on second data bus
  output logic             bus_valid_o,       // Bus words updated last edge
  output logic             limit_flag_o,      // Latched limit flag of the status word
  output logic [55:0]      pre_out_o,         // Pre-shifter result
  output logic [55:0]      bf_result_o,       // Bit-field result
  output logic [55:0]      first_acc_o,       // First accumulator contents
  output logic [55:0]      second_acc_o       // Second accumulator contents
);

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator storage and write decode

  logic [55:0] acc [2];
  logic [55:0] next_acc [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_acc
      wire         wr_hit  = wr_req_i.en && (wr_req_i.acc == 1'(g));
      wire         alu_hit = alu_wr_i && (alu_acc_i == 1'(g));
      wire  [23:0] wd      = wr_req_i.data[23:0];
      wire  [47:0] ld      = wr_req_i.data;
      logic [55:0] wr_val;
      // Sign fill keeps the binary point aligned for short operands
      always_comb begin
        unique case (wr_req_i.kind)
          WR_WORD:  wr_val = {{8{wd[23]}}, wd, 24'h000000};
          WR_LONG:  wr_val = {{8{ld[47]}}, ld};
          WR_TOP:   wr_val = {wd[7:0], acc[g][`UPPER_MSB:0]};
          WR_UPPER: wr_val = {acc[g][`TOP_MSB:`TOP_LSB], wd, acc[g][`LOWER_MSB:0]};
          WR_LOWER: wr_val = {acc[g][`TOP_MSB:`UPPER_LSB], wd};
          default:  wr_val = acc[g];
        endcase
      end
      // Bus writes win over an arithmetic result in the same cycle
      assign next_acc[g] = wr_hit ? wr_val : (alu_hit ? alu_data_i : acc[g]);
      // Reads never feed back here, so limiting leaves storage alone
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          acc[g] <= `ACC_RESET;
        end else begin
          acc[g] <= next_acc[g];
        end
      end
    end
  endgenerate

  assign first_acc_o  = acc[0];
  assign second_acc_o = acc[1];

  ////////////////////////////////////////////////////////////////////////////
  // Data shifter/limiter paths, one per bus

  // Shift by scaling first, then test the ten top bits for overflow
  function automatic logic [56:0] scale_shift(input logic [55:0] a, input scale_type s);
    logic [56:0] e;
    e = {a[55], a};
    unique case (s)
      SCALE_DOWN: e = {e[56], e[56:1]};
      SCALE_UP:   e = {e[55:0], 1'b0};
      default:    e = e;
    endcase
    return e;
  endfunction

  rd_req_type  req [2];
  logic [56:0] shifted [2];
  logic        ovf [2];
  logic [23:0] sh_word [2];
  logic [23:0] next_bus [2];
  logic        whole_rd [2];

  assign req[0] = rd_first_i;
  assign req[1] = rd_long_i ? rd_first_i : rd_second_i;

  generate
    for (g = 0; g < 2; g++) begin : g_path
      wire [55:0] src = acc[req[g].acc];
      assign shifted[g]  = scale_shift(src, scale_i);
      assign ovf[g]      = !((&shifted[g][56:47]) || !(|shifted[g][56:47]));
      assign sh_word[g]  = shifted[g][`UPPER_MSB:`UPPER_LSB];
      assign whole_rd[g] = req[g].en && (req[g].part == PART_WHOLE);
    end
  endgenerate

  // Long transfers use the first path's overflow for both words
  wire        long_ovf   = ovf[0];
  wire        neg        = shifted[0][56];
  wire [23:0] long_hi    = long_ovf ? (neg ? `SAT_NEG_HI : `SAT_POS_HI)
                                    : shifted[0][`UPPER_MSB:`UPPER_LSB];
  wire [23:0] long_lo    = long_ovf ? (neg ? `SAT_NEG_LO : `SAT_POS_LO)
                                    : shifted[0][`LOWER_MSB:0];

  // Per-bus word selection; part reads bypass the shifter and limiter
  generate
    for (g = 0; g < 2; g++) begin : g_sel
      wire [55:0] src  = acc[req[g].acc];
      wire [23:0] sat  = shifted[g][56] ? `SAT_NEG_HI : `SAT_POS_HI;
      wire [23:0] lim  = ovf[g] ? sat : sh_word[g];
      always_comb begin
        unique case (req[g].part)
          PART_TOP:   next_bus[g] = {{16{src[`TOP_MSB]}}, src[`TOP_MSB:`TOP_LSB]};
          PART_UPPER: next_bus[g] = src[`UPPER_MSB:`UPPER_LSB];
          PART_LOWER: next_bus[g] = src[`LOWER_MSB:0];
          default:    next_bus[g] = lim;
        endcase
      end
    end
  endgenerate

  wire        rd_any      = rd_first_i.en || (rd_second_i.en && !rd_long_i);
  wire        long_whole  = rd_long_i && whole_rd[0];
  wire [23:0] next_first  = long_whole ? long_hi : next_bus[0];
  wire [23:0] next_second = rd_long_i ? (whole_rd[0] ? long_lo : next_bus[0]) : next_bus[1];
  wire        sub_first   = whole_rd[0] && ovf[0];
  wire        sub_second  = !rd_long_i && whole_rd[1] && ovf[1];
  wire        substitute  = sub_first || sub_second;

  // Bus words hold their last value between reads
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_data_bus_o  <= 24'h000000;
      second_data_bus_o <= 24'h000000;
      bus_valid_o       <= 1'b0;
    end else begin
      first_data_bus_o  <= rd_first_i.en ? next_first : first_data_bus_o;
      second_data_bus_o <= (rd_long_i ? rd_first_i.en : rd_second_i.en) ? next_second
                                                                         : second_data_bus_o;
      bus_valid_o       <= rd_any;
    end
  end

  // Limit flag: a new substitution wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      limit_flag_o <= 1'b0;
    end else begin
      limit_flag_o <= substitute || (limit_flag_o && !limit_clr_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pre-accumulation shifter

  wire signed [55:0] pre_src = acc[pre_acc_i];
  logic [55:0]       next_pre;
  always_comb begin
    unique case (pre_mode_i)
      PRE_SHR24: next_pre = pre_src >>> `PRE_SHIFT_WORD;
      PRE_SHR16: next_pre = pre_src >>> `PRE_SHIFT_HALF;
      PRE_ZERO:  next_pre = 56'h00000000000000;
      default:   next_pre = pre_src;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_out_o <= 56'h00000000000000;
    end else begin
      pre_out_o <= next_pre;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-field block

  // Leading copies of the sign bit, not counting the sign bit itself
  function automatic logic [5:0] lead_count(input logic [55:0] a);
    logic [5:0] n;
    logic       run;
    n   = 6'h00;
    run = 1'b1;
    for (int i = 54; i >= 0; i--) begin
      run = run && (a[i] == a[55]);
      n   = n + 6'(run);
    end
    return n;
  endfunction

  wire signed [55:0] bf_a    = bf_req_i.a;
  wire        [55:0] bf_b    = bf_req_i.b;
  wire        [5:0]  bf_amt  = bf_req_i.amt;
  wire        [5:0]  bf_w    = bf_req_i.width;
  wire        [5:0]  bf_off  = bf_req_i.offset;
  // Low mask of width bits and the same mask moved to the offset
  wire        [55:0] low_mask = ~(56'hFFFFFFFFFFFFFF << bf_w);
  wire        [55:0] fld_mask = low_mask << bf_off;
  // Signed pull moves the field to the top and back down; unsigned pull shifts it down and masks
  wire        [6:0]  up_amt   = 7'd56 - 7'(bf_off) - 7'(bf_w);
  wire        [6:0]  dn_amt   = 7'd56 - 7'(bf_w);
  wire signed [55:0] pulled   = bf_a <<< up_amt;
  wire        [55:0] pull_s   = 56'(pulled >>> dn_amt);
  wire        [55:0] pull_u   = (bf_a >> bf_off) & low_mask;
  // Normalize shifts left by amt when b is positive, right by amt when b is negative
  wire        [55:0] norm_val = bf_b[55] ? 56'(bf_a >>> bf_amt) : 56'(bf_a <<< bf_amt);
  logic       [55:0] next_bf;

  always_comb begin
    unique case (bf_req_i.op)
      BF_SHIFT_LEFT_SIGNED:   next_bf = bf_a <<< bf_amt;
      BF_SHIFT_LEFT_PLAIN:    next_bf = bf_a << bf_amt;
      BF_SHIFT_RIGHT_SIGNED:  next_bf = bf_a >>> bf_amt;
      BF_SHIFT_RIGHT_PLAIN:   next_bf = bf_a >> bf_amt;
      BF_ROTATE_RIGHT_ONE:    next_bf = {bf_a[0], bf_a[55:1]};
      BF_ROTATE_LEFT_ONE:     next_bf = {bf_a[54:0], bf_a[55]};
      BF_FIELD_MERGE:         next_bf = (bf_a & ~low_mask) | (bf_b & low_mask);
      BF_FIELD_INSERT:        next_bf = (bf_a & ~fld_mask) | ((bf_b << bf_off) & fld_mask);
      BF_FIELD_PULL_SIGNED:   next_bf = pull_s;
      BF_FIELD_PULL_UNSIGNED: next_bf = pull_u;
      BF_LEADING_BIT_COUNT:   next_bf = {50'h0, lead_count(bf_a)};
      BF_FAST_NORMALIZE:      next_bf = norm_val;
      BF_AND:                 next_bf = bf_a & bf_b;
      BF_OR:                  next_bf = bf_a | bf_b;
      BF_EXCLUSIVE_OR_OP:     next_bf = bf_a ^ bf_b;
      BF_NOT:                 next_bf = ~bf_a;
      default:                next_bf = bf_a;
    endcase
  end

  // Result holds until the next request
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bf_result_o <= 56'h00000000000000;
    end else begin
      bf_result_o <= bf_req_i.en ? next_bf : bf_result_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Operand writes
  word_write_fill_a: assert property (wr_req_i.en && wr_req_i.kind == WR_WORD
      |=> acc[$past(wr_req_i.acc)] == {{8{$past(wr_req_i.data[23])}},
                                       $past(wr_req_i.data[23:0]), 24'h000000})
    else $error("word write not sign filled");
  long_write_fill_a: assert property (wr_req_i.en && wr_req_i.kind == WR_LONG
      |=> acc[$past(wr_req_i.acc)][55:48] == {8{$past(wr_req_i.data[47])}})
    else $error("long write top byte wrong");
  part_write_only_a: assert property (wr_req_i.en && wr_req_i.kind == WR_LOWER
      && !(alu_wr_i && alu_acc_i == wr_req_i.acc)
      |=> acc[$past(wr_req_i.acc)][55:24] == $past(acc[wr_req_i.acc][55:24]))
    else $error("lower write disturbed other parts");
  // A quiet cycle leaves storage alone whatever the buses read
  read_keeps_acc_a: assert property (!wr_req_i.en && !alu_wr_i
      |=> $stable(acc[0]) && $stable(acc[1]))
    else $error("accumulator changed by a read");

  // Part reads bypass scaling and limiting
  top_sign_fill_a: assert property (rd_first_i.en && rd_first_i.part == PART_TOP
      |=> first_data_bus_o[23:8] == {16{first_data_bus_o[7]}})
    else $error("top byte not sign extended");
  upper_raw_a: assert property (rd_second_i.en && !rd_long_i
      && rd_second_i.part == PART_UPPER
      |=> second_data_bus_o == $past(acc[rd_second_i.acc][47:24]))
    else $error("upper word read altered");
  lower_raw_a: assert property (rd_first_i.en && rd_first_i.part == PART_LOWER
      |=> first_data_bus_o == $past(acc[rd_first_i.acc][23:0]))
    else $error("lower word read altered");

  // Whole reads; the saturated word follows the accumulator sign
  sat_value_a: assert property (rd_first_i.en && !rd_long_i && whole_rd[0] && ovf[0]
      |=> first_data_bus_o == ($past(acc[rd_first_i.acc][55]) ? 24'h800000 : 24'h7FFFFF))
    else $error("saturation constant wrong");
  second_sat_a: assert property (!rd_long_i && whole_rd[1] && ovf[1]
      |=> second_data_bus_o == ($past(acc[rd_second_i.acc][55]) ? 24'h800000 : 24'h7FFFFF))
    else $error("second bus saturation wrong");
  long_sat_low_a: assert property (rd_long_i && whole_rd[0] && ovf[0]
      |=> second_data_bus_o == ($past(acc[rd_first_i.acc][55]) ? 24'h000000 : 24'hFFFFFF))
    else $error("long saturation low word wrong");
  no_limit_pass_a: assert property (rd_first_i.en && !rd_long_i && whole_rd[0]
      && scale_i == SCALE_NONE && (&acc[rd_first_i.acc][55:47] || !(|acc[rd_first_i.acc][55:47]))
      |=> first_data_bus_o == $past(acc[rd_first_i.acc][47:24]))
    else $error("unlimited value altered");
  reserved_scale_a: assert property (rd_first_i.en && !rd_long_i && whole_rd[0]
      && scale_i == SCALE_RSVD && (&acc[rd_first_i.acc][55:47] || !(|acc[rd_first_i.acc][55:47]))
      |=> first_data_bus_o == $past(acc[rd_first_i.acc][47:24]))
    else $error("reserved scaling code shifted");
  scaled_fit_a: assert property (!rd_long_i && whole_rd[1] && scale_i == SCALE_DOWN
      && (&acc[rd_second_i.acc][55:48] || !(|acc[rd_second_i.acc][55:48]))
      |=> second_data_bus_o == $past(acc[rd_second_i.acc][48:25]))
    else $error("scaled value limited");

  // The flag outlives the read that raised it until it is cleared
  flag_latch_a: assert property (substitute |=> limit_flag_o [*1] ##1
      (limit_flag_o || $past(limit_clr_i)))
    else $error("limit flag not latched");
  part_no_flag_a: assert property (limit_clr_i && !whole_rd[0] && !whole_rd[1]
      |=> !limit_flag_o)
    else $error("flag set without a whole read");
  bus_valid_a: assert property (rd_first_i.en |=> bus_valid_o)
    else $error("bus valid missing");

  // Pre-shifter and bit-field block
  pre_zero_a: assert property (pre_mode_i == PRE_ZERO
      |=> pre_out_o == 56'h00000000000000)
    else $error("pre-shifter zero failed");
  pre_word_shift_a: assert property (pre_mode_i == PRE_SHR24
      |=> pre_out_o == {{24{$past(acc[pre_acc_i][55])}}, $past(acc[pre_acc_i][55:24])})
    else $error("pre-shifter word shift wrong");
  bf_not_a: assert property (bf_req_i.en && bf_req_i.op == BF_NOT
      |=> bf_result_o == ~$past(bf_req_i.a))
    else $error("bit-field not wrong");

endmodule

/* tb/data_bus_sink.sv */
`timescale 1ns/1ps
// Far side model: the consumer on the first bus takes a word whenever one is presented
module data_bus_sink (
  input  wire logic        ref_clk_i,    // Core clock
  input  wire logic        rst_n_i,      // Asynchronous reset, active low
  input  wire logic        bus_valid_i,  // Words presented this cycle
  input  wire logic [23:0] first_word_i, // First data bus word
  output logic [15:0]      words_seen_o, // Count of presented cycles
  output logic [23:0]      first_seen_o  // Last word taken from first bus
);
  // Counting lets the bench confirm that no read was lost or doubled
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      words_seen_o <= 16'h0000;
      first_seen_o <= 24'h000000;
    end else if (bus_valid_i) begin
      words_seen_o <= words_seen_o + 16'h0001;
      first_seen_o <= first_word_i;
    end
  end
endmodule

/* tb/tb_accumulator_transfer_limiter.sv */
`timescale 1ns/1ps
module tb_accumulator_transfer_limiter;
  import acc_xfer_pkg::*;
  logic ref_clk_i, rst_n_i, rd_long, alu_wr, alu_acc, pre_acc, limit_clr, bus_valid_o, limit_flag_o;
  scale_type    scale;
  rd_req_type   rd_f, rd_s;
  wr_req_type   wr;
  pre_mode_type pre_mode;
  bf_req_type   bf;
  logic [55:0]  alu_data, pre_out_o, bf_result_o, first_acc_o, second_acc_o;
  logic [23:0]  first_data_bus_o, second_data_bus_o, first_seen;
  logic [15:0]  words_seen;
  int           miscompares, tests_run, reads;
  localparam rd_req_type OFF = '{1'b0, 1'b0, PART_WHOLE};

  accumulator_transfer_limiter u_accumulator_transfer_limiter (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scale_i(scale), .rd_first_i(rd_f),
    .rd_second_i(rd_s), .rd_long_i(rd_long), .wr_req_i(wr), .alu_wr_i(alu_wr),
    .alu_acc_i(alu_acc), .alu_data_i(alu_data), .pre_acc_i(pre_acc), .pre_mode_i(pre_mode),
    .bf_req_i(bf), .limit_clr_i(limit_clr), .first_data_bus_o(first_data_bus_o),
    .second_data_bus_o(second_data_bus_o), .bus_valid_o(bus_valid_o),
    .limit_flag_o(limit_flag_o), .pre_out_o(pre_out_o), .bf_result_o(bf_result_o),
    .first_acc_o(first_acc_o), .second_acc_o(second_acc_o));
  data_bus_sink u_data_bus_sink (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_valid_i(bus_valid_o),
    .first_word_i(first_data_bus_o), .words_seen_o(words_seen), .first_seen_o(first_seen));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard, well above the fewer than one hundred cycles the tests need
  initial begin
    #60000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers; inputs move 1 ns after the edge so sampling never races
  task automatic cyc;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_wide(input logic [55:0] got, input logic [55:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // Request tasks let an idle edge pass first, so a strobe never drops and rises in one step
  task automatic wr_op(input logic acc, input wr_kind_type kind, input logic [47:0] data);
    cyc();
    wr = '{1'b1, acc, kind, data};
    cyc();
    wr.en = 1'b0;
  endtask
  // One read cycle; the words stand from the edge that takes the request
  task automatic rd_op(input logic lg, input rd_req_type f, input rd_req_type s);
    cyc();
    rd_long = lg;
    rd_f = f;
    rd_s = s;
    cyc();
    reads++;
    rd_f = OFF;
    rd_s = OFF;
    rd_long = 1'b0;
    chk_bit(bus_valid_o, 1'b1, "valid");
  endtask
  task automatic clr_flag;
    limit_clr = 1'b1;
    cyc();
    limit_clr = 1'b0;
    chk_bit(limit_flag_o, 1'b0, "flag clear");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Operand writes and the arithmetic path
  task automatic t_writes;
    wr_op(1'b0, WR_WORD, 48'h000000800000);
    chk_wide(first_acc_o, 56'hFF800000000000, "word");
    wr_op(1'b0, WR_LONG, 48'h7FFFFF123456);
    chk_wide(first_acc_o, 56'h007FFFFF123456, "long");
    wr_op(1'b0, WR_UPPER, 48'h000000800000);
    chk_wide(first_acc_o, 56'h00800000123456, "upper");
    wr_op(1'b0, WR_LOWER, 48'h000000ABCDEF);
    chk_wide(first_acc_o, 56'h00800000ABCDEF, "lower");
    rd_op(1'b0, '{1'b1, 1'b0, PART_LOWER}, '{1'b1, 1'b0, PART_WHOLE});
    chk_word(first_data_bus_o, 24'hABCDEF, "lower raw");
    chk_word(second_data_bus_o, 24'h7FFFFF, "sign overflow");
    // Both accumulators are written in the same cycle from different sources
    {alu_wr, alu_acc, alu_data} = {1'b1, 1'b1, 56'h01000000000000};
    wr_op(1'b0, WR_TOP, 48'h0000000000FF);
    chk_wide(first_acc_o, 56'hFF800000ABCDEF, "top");
    chk_wide(second_acc_o, 56'h01000000000000, "alu");
    alu_acc = 1'b0;
    wr_op(1'b0, WR_WORD, 48'h000000123456);
    alu_wr = 1'b0;
    chk_wide(first_acc_o, 56'h00123456000000, "bus wins");
  endtask

  // Whole and part reads at no scaling
  task automatic t_reads;
    clr_flag();
    rd_op(1'b0, '{1'b1, 1'b0, PART_WHOLE}, OFF);
    chk_word(first_data_bus_o, 24'h123456, "fits");
    chk_bit(limit_flag_o, 1'b0, "no limit");
    rd_op(1'b0, '{1'b1, 1'b0, PART_WHOLE}, '{1'b1, 1'b1, PART_WHOLE});
    chk_word(first_data_bus_o, 24'h123456, "pair first");
    chk_word(second_data_bus_o, 24'h7FFFFF, "pos sat");
    chk_wide(second_acc_o, 56'h01000000000000, "acc kept");
    cyc();
    cyc();
    chk_bit(limit_flag_o, 1'b1, "latched");
    clr_flag();
    wr_op(1'b1, WR_TOP, 48'h000000000080);
    rd_op(1'b0, OFF, '{1'b1, 1'b1, PART_WHOLE});
    chk_word(second_data_bus_o, 24'h800000, "neg sat");
    clr_flag();
    rd_op(1'b0, '{1'b1, 1'b1, PART_TOP}, '{1'b1, 1'b1, PART_UPPER});
    chk_word(first_data_bus_o, 24'hFFFF80, "top fill");
    chk_word(second_data_bus_o, 24'h000000, "upper raw");
    chk_bit(limit_flag_o, 1'b0, "part no flag");
    rd_op(1'b1, '{1'b1, 1'b1, PART_WHOLE}, OFF);
    chk_word(first_data_bus_o, 24'h800000, "long neg hi");
    chk_word(second_data_bus_o, 24'h000000, "long neg lo");
    wr_op(1'b1, WR_TOP, 48'h000000000001);
    rd_op(1'b1, '{1'b1, 1'b1, PART_WHOLE}, '{1'b1, 1'b0, PART_WHOLE});
    chk_word(first_data_bus_o, 24'h7FFFFF, "long pos hi");
    chk_word(second_data_bus_o, 24'hFFFFFF, "long pos lo");
    rd_op(1'b1, '{1'b1, 1'b0, PART_WHOLE}, OFF);
    chk_word(first_data_bus_o, 24'h123456, "long fit hi");
    chk_word(second_data_bus_o, 24'h000000, "long fit lo");
  endtask

  // Every scaling code, then a value that only fits after scaling down
  task automatic t_scale;
    logic [23:0] exp [4] = '{24'h400000, 24'h200000, 24'h7FFFFF, 24'h400000};
    wr_op(1'b0, WR_WORD, 48'h000000400000);
    for (int i = 0; i < 4; i++) begin
      scale = scale_type'(i[1:0]);
      rd_op(1'b0, '{1'b1, 1'b0, PART_WHOLE}, OFF);
      chk_word(first_data_bus_o, exp[i], "scale");
    end
    wr_op(1'b0, WR_TOP, 48'h0000000000FF);
    scale = SCALE_NONE;
    rd_op(1'b0, OFF, '{1'b1, 1'b0, PART_WHOLE});
    chk_word(second_data_bus_o, 24'h800000, "unscaled sat");
    scale = SCALE_DOWN;
    rd_op(1'b0, OFF, '{1'b1, 1'b0, PART_WHOLE});
    chk_word(second_data_bus_o, 24'hA00000, "scaled fits");
    scale = SCALE_NONE;
  endtask

  // Pre-accumulation shifter on the first accumulator, FF400000000000, then a pass of the second
  task automatic t_pre;
    logic [55:0] exp [4] = '{56'hFF400000000000, 56'hFFFFFFFF400000,
                             56'hFFFFFF40000000, 56'h00000000000000};
    for (int i = 0; i < 4; i++) begin
      pre_mode = pre_mode_type'(i[1:0]);
      cyc();
      chk_wide(pre_out_o, exp[i], "pre");
    end
    pre_acc = 1'b1;
    pre_mode = PRE_PASS;
    cyc();
    chk_wide(pre_out_o, 56'h01000000000000, "pre second");
  endtask

  task automatic bf_one(input bf_op_type op, input logic [55:0] a, input logic [55:0] b,
                        input logic [5:0] w, input logic [5:0] o, input logic [55:0] exp);
    cyc();
    bf = '{1'b1, op, a, b, 6'h04, w, o};
    cyc();
    bf.en = 1'b0;
    chk_wide(bf_result_o, exp, "bit field");
  endtask
  task automatic t_bf;
    logic [55:0] a = 56'h80000000000001;
    logic [55:0] m = 56'h00000000000003;
    bf_one(BF_SHIFT_LEFT_SIGNED, a, m, 6'h00, 6'h00, 56'h00000000000010);
    bf_one(BF_SHIFT_LEFT_PLAIN, a, m, 6'h00, 6'h00, 56'h00000000000010);
    bf_one(BF_SHIFT_RIGHT_SIGNED, a, m, 6'h00, 6'h00, 56'hF8000000000000);
    bf_one(BF_SHIFT_RIGHT_PLAIN, a, m, 6'h00, 6'h00, 56'h08000000000000);
    bf_one(BF_ROTATE_RIGHT_ONE, a, m, 6'h00, 6'h00, 56'hC0000000000000);
    bf_one(BF_ROTATE_LEFT_ONE, a, m, 6'h00, 6'h00, 56'h00000000000003);
    bf_one(BF_FIELD_MERGE, '0, 56'hFF, 6'h04, 6'h00, 56'h0000000000000F);
    bf_one(BF_FIELD_INSERT, '0, 56'hF, 6'h04, 6'h08, 56'h00000000000F00);
    bf_one(BF_FIELD_PULL_SIGNED, 56'hF0, m, 6'h04, 6'h04, 56'hFFFFFFFFFFFFFF);
    bf_one(BF_FIELD_PULL_UNSIGNED, 56'hF0, m, 6'h04, 6'h04, 56'h0000000000000F);
    bf_one(BF_LEADING_BIT_COUNT, 56'h0F000000000000, m, 6'h00, 6'h00, 56'h3);
    bf_one(BF_FAST_NORMALIZE, 56'h1, '0, 6'h00, 6'h00, 56'h00000000000010);
    bf_one(BF_AND, a, m, 6'h00, 6'h00, 56'h00000000000001);
    bf_one(BF_OR, a, m, 6'h00, 6'h00, 56'h80000000000003);
    bf_one(BF_EXCLUSIVE_OR_OP, a, m, 6'h00, 6'h00, 56'h80000000000002);
    bf_one(BF_NOT, a, m, 6'h00, 6'h00, 56'h7FFFFFFFFFFFFE);
  endtask

  task automatic finish_test;
    $display("Counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n_i, rd_long, alu_wr, alu_acc, pre_acc, limit_clr} = '0;
    {rd_f, rd_s, wr, bf, alu_data} = '0;
    scale = SCALE_NONE;
    pre_mode = PRE_PASS;
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    t_writes();
    t_reads();
    t_scale();
    t_pre();
    t_bf();
    cyc();
    chk_wide({40'h0, words_seen}, 56'(reads), "reads seen");
    chk_word(first_seen, 24'h400000, "last first word");
    finish_test();
  end
endmodule
